// File: ctm_cfg.svh
// Register offsets, field positions, reset values and mode codes
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

`define CTM_ADDR_W          16
`define CTM_ADDR_OR_MASK    16'h9E0C
`define CTM_ADDR_AND_MASK   16'h9E10
`define CTM_ADDR_STATUS     16'h9E14
`define CTM_ADDR_AVAIL      16'h9E98
`define CTM_ADDR_CH0_SEL    16'h9EA2
`define CTM_ADDR_CH1_SEL    16'h9EA3
`define CTM_ADDR_CH0_LVL0   16'hA4D8
`define CTM_ADDR_CH1_LVL0   16'hA4D9
`define CTM_ADDR_CH0_LVL1   16'hA53C
`define CTM_ADDR_CH1_LVL1   16'hA53D

`define CTM_CH0_MASK_BIT    0
`define CTM_CH1_MASK_BIT    1
`define CTM_STAT_ERR_BIT    0
`define CTM_STAT_HIT_LSB    8

`define CTM_RST_MASK        2'h0
`define CTM_RST_MODE        32'h00000000
`define CTM_RST_LEVEL       10'h000

`define CTM_TRIGGER_DISABLED_CODE 32'h00000000
`define CTM_RISING_EDGE_CODE      32'h00000001
`define CTM_FALLING_EDGE_CODE     32'h00000002
`define CTM_EITHER_EDGE_CODE      32'h00000004
`define CTM_ABOVE_LEVEL_CODE      32'h00000008
`define CTM_BELOW_LEVEL_CODE      32'h00000010
`define CTM_WINDOW_ENTRY_CODE     32'h00000020
`define CTM_WINDOW_EXIT_CODE      32'h00000040
`define CTM_INSIDE_WINDOW_CODE    32'h00000080
`define CTM_OUTSIDE_WINDOW_CODE   32'h00000100
`define CTM_HYSTERESIS_ARM_FLAG   32'h01000000
`define CTM_MODES_AVAILABLE       32'h010001FF

`endif

// File: ctm_pkg.sv
// Types shared by the channel trigger block
`include "ctm_cfg.svh"

package ctm_pkg;

	typedef logic [31:0] ctm_word_t;

	typedef enum logic [31:0]
	{
		CTM_NONE     = `CTM_TRIGGER_DISABLED_CODE,
		CTM_POS      = `CTM_RISING_EDGE_CODE,
		CTM_NEG      = `CTM_FALLING_EDGE_CODE,
		CTM_BOTH     = `CTM_EITHER_EDGE_CODE,
		CTM_HIGH     = `CTM_ABOVE_LEVEL_CODE,
		CTM_LOW      = `CTM_BELOW_LEVEL_CODE,
		CTM_WIN_IN   = `CTM_WINDOW_ENTRY_CODE,
		CTM_WIN_OUT  = `CTM_WINDOW_EXIT_CODE,
		CTM_INSIDE   = `CTM_INSIDE_WINDOW_CODE,
		CTM_OUTSIDE  = `CTM_OUTSIDE_WINDOW_CODE,
		CTM_POS_ARM  = `CTM_HYSTERESIS_ARM_FLAG | `CTM_RISING_EDGE_CODE,
		CTM_NEG_ARM  = `CTM_HYSTERESIS_ARM_FLAG | `CTM_FALLING_EDGE_CODE
	} ctm_mode_t;

endpackage

// File: ctm_channel_trigger.sv
// Two-channel trigger detector with register port
//
// Function
// R1: Software enables each programmed channel in mask
// R2: OR mask bit 0 enables channel zero
// R3: Read-only bitmask lists supported trigger modes
// R4: Separate read/write mode register per channel
// R5: Mode write to unfitted channel flags error
// R6: Mode zero excludes channel from detection
// R7: Code 1h detects rising level crossings
// R8: Code 2h detects falling level crossings
// R9: Code 4h detects both crossing directions
// R10: Rising on level0, armed below level1
// R11: Falling on level1, armed above level0
// R12: Code 10h detects sample below level
// R13: Code 8h detects sample above level
// R14: Code 20h detects window entry
// R15: Code 40h detects window exit
// R16: Code 80h detects sample inside window
// R17: Code 100h detects sample outside window
// R18: Channels combine singly, by OR, AND
// R19: Two signed levels per channel held
// R20: Top N sample bits compared to levels
// R21: Every sample evaluated, no decimation
// R22: Rising edge: consecutive samples pass level
// R23: Software clears general mask for channel-only
// R24: One trigger on first qualifying sample; the code pulses o_trig on every qualifying sample
`timescale 1ns/1ps
`include "ctm_cfg.svh"

module ctm_channel_trigger
#(
	parameter int CH_FITTED = 2,
	parameter int SMP_W     = 14,
	parameter int LVL_W     = 10
)
(
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rstn,
	// Register port
	input  wire logic [`CTM_ADDR_W-1:0] i_addr,
	input  wire logic [31:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [31:0]            o_rdata,
	// Sample stream
	input  wire logic                   i_smp_valid,
	input  wire logic [SMP_W-1:0]       i_ch0_smp,
	input  wire logic [SMP_W-1:0]       i_ch1_smp,
	// Trigger outputs
	output logic                        o_trig,
	output logic      [1:0]             o_ch_hit,
	output logic                        o_err
);

	typedef struct packed
	{
		logic [1:0]                  or_mask;
		logic [1:0]                  and_mask;
		logic [1:0][31:0]            mode;
		logic [1:0][LVL_W-1:0]       lvl0;
		logic [1:0][LVL_W-1:0]       lvl1;
		logic [1:0][LVL_W-1:0]       prev;
		logic [1:0]                  prev_ok;
		logic [1:0]                  armed;
		logic                        err;
		logic [1:0]                  hit;
		logic                        trig;
		logic [31:0]                 rdata;
	} ctm_state_t;

	ctm_state_t state_reg;
	ctm_state_t state_next;

	logic [1:0]           fitted;
	logic [1:0][SMP_W-1:0] smp;

	assign fitted = (CH_FITTED >= 2) ? 2'h3 : 2'h1;
	assign smp[0] = i_ch0_smp;
	assign smp[1] = i_ch1_smp;

	// Sign-extend a level to a register word
	function automatic logic [31:0] ctm_sext(input logic [LVL_W-1:0] v);
		logic [31:0] r;
		r = {{(32-LVL_W){v[LVL_W-1]}}, v};
		return r;
	endfunction

	// True when x lies in the window lo..hi
	function automatic logic ctm_inwin(
		input logic signed [LVL_W-1:0] x,
		input logic signed [LVL_W-1:0] hi,
		input logic signed [LVL_W-1:0] lo
	);
		logic r;
		r = (x >= lo) && (x <= hi);
		return r;
	endfunction

	// Per-channel detector: returns {armed_next, hit}
	function automatic logic [1:0] ctm_detect(
		input logic [31:0]             mode,
		input logic signed [LVL_W-1:0] cur,
		input logic signed [LVL_W-1:0] prv,
		input logic                    prv_ok,
		input logic signed [LVL_W-1:0] l0,
		input logic signed [LVL_W-1:0] l1,
		input logic                    armed
	);
		logic rise0;
		logic fall0;
		logic fall1;
		logic in_c;
		logic in_p;
		logic hit;
		logic arm_n;
		rise0 = prv_ok && (prv < l0) && (cur >= l0); // R22
		fall0 = prv_ok && (prv >= l0) && (cur < l0);
		fall1 = prv_ok && (prv >= l1) && (cur < l1);
		in_c  = ctm_inwin(cur, l0, l1);
		in_p  = ctm_inwin(prv, l0, l1);
		hit   = 1'b0;
		arm_n = 1'b0;
		case (mode)
			ctm_pkg::CTM_NONE:
				hit = 1'b0; // R6
			ctm_pkg::CTM_POS:
				hit = rise0; // R7
			ctm_pkg::CTM_NEG:
				hit = fall0; // R8
			ctm_pkg::CTM_BOTH:
				hit = rise0 | fall0; // R9
			ctm_pkg::CTM_POS_ARM:
			begin
				hit   = armed && rise0; // R10
				arm_n = (cur < l1) ? 1'b1 : (hit ? 1'b0 : armed); // R10
			end
			ctm_pkg::CTM_NEG_ARM:
			begin
				hit   = armed && fall1; // R11
				arm_n = (cur > l0) ? 1'b1 : (hit ? 1'b0 : armed); // R11
			end
			ctm_pkg::CTM_LOW:
				hit = cur < l0; // R12
			ctm_pkg::CTM_HIGH:
				hit = cur > l0; // R13
			ctm_pkg::CTM_WIN_IN:
				hit = prv_ok && !in_p && in_c; // R14
			ctm_pkg::CTM_WIN_OUT:
				hit = prv_ok && in_p && !in_c; // R15
			ctm_pkg::CTM_INSIDE:
				hit = in_c; // R16
			ctm_pkg::CTM_OUTSIDE:
				hit = !in_c; // R17
			default:
				hit = 1'b0;
		endcase
		return {arm_n, hit};
	endfunction

	// Mode register address of a channel
	function automatic logic [`CTM_ADDR_W-1:0] ctm_sel_addr(input int c);
		logic [`CTM_ADDR_W-1:0] r;
		r = (c == 0) ? `CTM_ADDR_CH0_SEL : `CTM_ADDR_CH1_SEL;
		return r;
	endfunction

	// True for any channel one register address
	function automatic logic ctm_is_ch1(input logic [`CTM_ADDR_W-1:0] a);
		logic r;
		r = (a == `CTM_ADDR_CH1_SEL) || (a == `CTM_ADDR_CH1_LVL0) ||
			(a == `CTM_ADDR_CH1_LVL1);
		return r;
	endfunction

	// Combined trigger from channel hits and both masks
	function automatic logic ctm_combine(
		input logic [1:0] hit,
		input logic [1:0] en_or,
		input logic [1:0] en_and
	);
		logic r;
		r = (|(hit & en_or)) || // R24
			((en_and != 2'h0) && ((hit & en_and) == en_and)); // R18
		return r;
	endfunction

	always_comb
	begin
		logic [1:0]       en_or;
		logic [1:0]       en_and;
		logic [1:0]       hit_now;
		logic [1:0]       det;
		logic [LVL_W-1:0] top;
		logic             ch_sel;
		state_next = state_reg;
		en_or      = 2'h0;
		en_and     = 2'h0;
		hit_now    = 2'h0;
		det        = 2'h0;
		top        = '0;
		ch_sel     = 1'b0;

		// Register writes
		if (i_wr)
		begin
			case (i_addr)
				`CTM_ADDR_OR_MASK:
					state_next.or_mask = i_wdata[1:0] & fitted; // R2
				`CTM_ADDR_AND_MASK:
					state_next.and_mask = i_wdata[1:0] & fitted; // R18
				`CTM_ADDR_STATUS:
					if (i_wdata[`CTM_STAT_ERR_BIT])
					begin
						state_next.err = 1'b0;
					end
				`CTM_ADDR_CH0_SEL:
				begin
					state_next.mode[0]  = i_wdata; // R4
					state_next.armed[0] = 1'b0;
				end
				`CTM_ADDR_CH1_SEL:
				begin
					if (fitted[1])
					begin
						state_next.mode[1]  = i_wdata; // R4
						state_next.armed[1] = 1'b0;
					end
				end
				`CTM_ADDR_CH0_LVL0:
					state_next.lvl0[0] = i_wdata[LVL_W-1:0]; // R19
				`CTM_ADDR_CH1_LVL0:
					if (fitted[1])
					begin
						state_next.lvl0[1] = i_wdata[LVL_W-1:0]; // R19
					end
				`CTM_ADDR_CH0_LVL1:
					state_next.lvl1[0] = i_wdata[LVL_W-1:0]; // R19
				`CTM_ADDR_CH1_LVL1:
					if (fitted[1])
					begin
						state_next.lvl1[1] = i_wdata[LVL_W-1:0]; // R19
					end
				default:
					state_next.err = state_next.err;
			endcase
		end

		// Sample evaluation, one result per sample
		state_next.trig = 1'b0;
		state_next.hit  = 2'h0;
		if (i_smp_valid) // R21
		begin
			for (int c = 0; c < 2; c++)
			begin
				top = smp[c][SMP_W-1 -: LVL_W]; // R20
				if (fitted[c])
				begin
					det = ctm_detect(state_reg.mode[c], top, state_reg.prev[c],
						state_reg.prev_ok[c], state_reg.lvl0[c],
						state_reg.lvl1[c], state_reg.armed[c]);
					hit_now[c] = det[0];
					if (!(i_wr && (i_addr == ctm_sel_addr(c))))
					begin
						state_next.armed[c] = det[1];
					end
					state_next.prev[c]    = top;
					state_next.prev_ok[c] = 1'b1;
				end
			end
			en_or  = state_reg.or_mask & fitted; // R1
			en_and = state_reg.and_mask & fitted;
			state_next.hit  = hit_now;
			state_next.trig = ctm_combine(hit_now, en_or, en_and); // R18 R24
		end

		// Unfitted channel write sets error; set wins over clear
		ch_sel = ctm_is_ch1(i_addr);
		if (i_wr && ch_sel && !fitted[1])
		begin
			state_next.err = 1'b1; // R5
		end

		// Register reads, data in the following cycle
		state_next.rdata = 32'h00000000;
		if (i_rd)
		begin
			case (i_addr)
				`CTM_ADDR_OR_MASK:
					state_next.rdata = {30'h00000000, state_reg.or_mask};
				`CTM_ADDR_AND_MASK:
					state_next.rdata = {30'h00000000, state_reg.and_mask};
				`CTM_ADDR_STATUS:
				begin
					state_next.rdata[`CTM_STAT_ERR_BIT] = state_reg.err;
					state_next.rdata[`CTM_STAT_HIT_LSB +: 2] = state_reg.hit;
				end
				`CTM_ADDR_AVAIL:
					state_next.rdata = `CTM_MODES_AVAILABLE; // R3
				`CTM_ADDR_CH0_SEL:
					state_next.rdata = state_reg.mode[0];
				`CTM_ADDR_CH1_SEL:
					state_next.rdata = fitted[1] ? state_reg.mode[1] : 32'h00000000;
				`CTM_ADDR_CH0_LVL0:
					state_next.rdata = ctm_sext(state_reg.lvl0[0]);
				`CTM_ADDR_CH1_LVL0:
					state_next.rdata = ctm_sext(state_reg.lvl0[1]);
				`CTM_ADDR_CH0_LVL1:
					state_next.rdata = ctm_sext(state_reg.lvl1[0]);
				`CTM_ADDR_CH1_LVL1:
					state_next.rdata = ctm_sext(state_reg.lvl1[1]);
				default:
					state_next.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
		begin
			state_reg.or_mask  <= `CTM_RST_MASK;
			state_reg.and_mask <= `CTM_RST_MASK;
			state_reg.mode     <= {2{`CTM_RST_MODE}};
			state_reg.lvl0     <= {2{`CTM_RST_LEVEL}};
			state_reg.lvl1     <= {2{`CTM_RST_LEVEL}};
			state_reg.prev     <= {2{`CTM_RST_LEVEL}};
			state_reg.prev_ok  <= 2'h0;
			state_reg.armed    <= 2'h0;
			state_reg.err      <= 1'b0;
			state_reg.hit      <= 2'h0;
			state_reg.trig     <= 1'b0;
			state_reg.rdata    <= 32'h00000000;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign o_rdata  = state_reg.rdata;
	assign o_trig   = state_reg.trig;
	assign o_ch_hit = state_reg.hit;
	assign o_err    = state_reg.err;

endmodule

// File: ctm_trigger_asserts.sv
// Port assertions for the channel trigger block
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_trigger_asserts
#(
	parameter int CH_FITTED = 2
)
(
	// Watched ports
	input wire logic                   i_clk_sys,
	input wire logic                   i_rstn,
	input wire logic [`CTM_ADDR_W-1:0] i_addr,
	input wire logic [31:0]            i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [31:0]            o_rdata,
	input wire logic                   i_smp_valid,
	input wire logic                   o_trig,
	input wire logic [1:0]             o_ch_hit,
	input wire logic                   o_err
);
	localparam logic [1:0] FIT = (CH_FITTED >= 2) ? 2'h3 : 2'h1;
	logic [1:0] or_reg;
	logic [1:0] and_reg;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// Shadow copies of the two masks
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rstn)
		begin
			or_reg  <= 2'h0;
			and_reg <= 2'h0;
		end
		else if (i_wr)
		begin
			if (i_addr == `CTM_ADDR_OR_MASK)
				or_reg <= i_wdata[1:0] & FIT;
			if (i_addr == `CTM_ADDR_AND_MASK)
				and_reg <= i_wdata[1:0] & FIT;
		end
	end
	sequence s_avail_rd;
		i_rd && i_addr == `CTM_ADDR_AVAIL;
	endsequence
	sequence s_ch1_wr;
		i_wr && (i_addr == `CTM_ADDR_CH1_SEL || i_addr == `CTM_ADDR_CH1_LVL0);
	endsequence
	a_rdata_idle: assert property ($past(i_rd) == 1'b0 |-> o_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_avail_read: assert property (s_avail_rd |=> o_rdata == `CTM_MODES_AVAILABLE)
		else $error("capability mask wrong");
	a_no_valid: assert property (!i_smp_valid |=> o_ch_hit == 2'h0 && !o_trig)
		else $error("hit without sample");
	a_trig_hit: assert property (o_trig |-> o_ch_hit != 2'h0)
		else $error("trigger without channel hit");
	a_trig_mask: assert property (o_trig == ((o_ch_hit & $past(or_reg)) != 2'h0
		|| ($past(and_reg) != 2'h0 && (o_ch_hit & $past(and_reg)) == $past(and_reg))))
		else $error("trigger does not follow masks");
	a_err_hold: assert property (o_err && !(i_wr && i_addr == `CTM_ADDR_STATUS
		&& i_wdata[0]) |=> o_err)
		else $error("error flag dropped");
	a_err_set: assert property (s_ch1_wr |=> o_err == (CH_FITTED < 2))
		else $error("unfitted channel write not flagged");
	a_err_fitted: assert property (CH_FITTED > 1 |-> !o_err)
		else $error("error on fitted board");
endmodule
bind ctm_channel_trigger ctm_trigger_asserts #(.CH_FITTED(CH_FITTED)) u_chk
(
	.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid),
	.o_trig(o_trig), .o_ch_hit(o_ch_hit), .o_err(o_err)
);

// File: ctm_adc_model.sv
// Converter sample stream model
`timescale 1ns/1ps
module ctm_adc_model
(
	// Clock and request
	input  wire logic       i_clk_sys,
	input  wire logic       i_send,
	input  wire logic [9:0] i_top0,
	input  wire logic [9:0] i_top1,
	// Sample stream
	output logic            o_smp_valid,
	output logic [13:0]     o_ch0_smp,
	output logic [13:0]     o_ch1_smp
);
	logic [3:0] lsb_reg;
	initial
	begin
		lsb_reg     = 4'h5;
		o_smp_valid = 1'b0;
		o_ch0_smp   = 14'h0000;
		o_ch1_smp   = 14'h3FFF;
	end
	// Stale words toggle, low bits always move
	always @(posedge i_clk_sys)
	begin
		lsb_reg     <= lsb_reg + 4'h1;
		o_smp_valid <= i_send;
		o_ch0_smp   <= i_send ? {i_top0, lsb_reg} : ~o_ch0_smp;
		o_ch1_smp   <= i_send ? {i_top1, ~lsb_reg} : ~o_ch1_smp;
	end
endmodule

// File: tb_top.sv
// Self-checking bench for the channel trigger block
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module tb_top;
	typedef struct packed
	{
		logic [31:0] mode;
		logic [9:0]  prev;
		logic [9:0]  cur;
		logic        hit;
	} ctm_row_t;
	localparam logic [9:0] LO = 10'h3EC;
	localparam logic [9:0] HI = 10'h014;
	localparam logic [9:0] Z  = 10'h000;
	logic                   i_clk_sys;
	logic                   i_rstn;
	logic [`CTM_ADDR_W-1:0] i_addr;
	logic [31:0]            i_wdata;
	logic                   i_wr;
	logic                   i_rd;
	logic                   send;
	logic [9:0]             top0;
	logic [9:0]             top1;
	logic                   smp_valid;
	logic [13:0]            ch0_smp;
	logic [13:0]            ch1_smp;
	logic [31:0]            rdata [2];
	logic [1:0]             hit [2];
	logic                   trig [2];
	logic                   err [2];
	logic [2:0]             o3;
	int                     n_mismatch;
	int                     n_compared;
	int                     n_cyc;
	ctm_row_t               rows [18];
	ctm_adc_model adc
	(
		.i_clk_sys(i_clk_sys), .i_send(send), .i_top0(top0), .i_top1(top1),
		.o_smp_valid(smp_valid), .o_ch0_smp(ch0_smp), .o_ch1_smp(ch1_smp)
	);
	ctm_channel_trigger dut
	(
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata[0]), .i_smp_valid(smp_valid),
		.i_ch0_smp(ch0_smp), .i_ch1_smp(ch1_smp), .o_trig(trig[0]), .o_ch_hit(hit[0]),
		.o_err(err[0])
	);
	ctm_channel_trigger #(.CH_FITTED(1)) dut_one
	(
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata[1]), .i_smp_valid(smp_valid),
		.i_ch0_smp(ch0_smp), .i_ch1_smp(ch1_smp), .o_trig(trig[1]), .o_ch_hit(hit[1]),
		.o_err(err[1])
	);
	initial
	begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge i_clk_sys)
	begin
		n_cyc++;
		if (n_cyc == 4000)
		begin
			n_mismatch++;
			end_of_test;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rst(input int n);
		@(posedge i_clk_sys);
		i_rstn <= 1'b0;
		repeat (n) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input int u, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(rdata[u], e);
	endtask
	task automatic smp(input logic [9:0] a, input logic [9:0] b);
		@(posedge i_clk_sys);
		send <= 1'b1;
		top0 <= a;
		top1 <= b;
		@(posedge i_clk_sys);
		send <= 1'b0;
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic cmb(input logic [1:0] om, input logic [1:0] am, input logic [9:0] a,
		input logic [9:0] b, input logic [2:0] e);
		wr(`CTM_ADDR_OR_MASK, {30'h0, om});
		wr(`CTM_ADDR_AND_MASK, {30'h0, am});
		smp(a, b);
		chk({29'h0, trig[0], hit[0]}, {29'h0, e});
	endtask
	initial
	begin
		{i_rstn, i_wr, i_rd, send, i_addr, i_wdata, top0, top1} = '0;
		{n_mismatch, n_compared, n_cyc} = '0;
		rows = '{'{32'h00000000, LO, HI, 1'b0}, '{32'h00000001, LO, HI, 1'b1},
			'{32'h00000001, HI, LO, 1'b0}, '{32'h00000002, HI, LO, 1'b1},
			'{32'h00000004, HI, LO, 1'b1}, '{32'h00000004, LO, HI, 1'b1},
			'{32'h01000001, LO, HI, 1'b1}, '{32'h01000001, Z, HI, 1'b0},
			'{32'h01000002, HI, LO, 1'b1}, '{32'h01000002, Z, LO, 1'b0},
			'{32'h00000008, Z, 10'h008, 1'b0}, '{32'h00000008, Z, 10'h009, 1'b1},
			'{32'h00000010, Z, LO, 1'b1}, '{32'h00000020, HI, Z, 1'b1},
			'{32'h00000040, Z, LO, 1'b1}, '{32'h00000080, Z, 10'h008, 1'b1},
			'{32'h00000080, Z, 10'h009, 1'b0}, '{32'h00000100, Z, 10'h3F7, 1'b1}};
		rst(10);
		rd(`CTM_ADDR_OR_MASK, 0, 32'h0);
		rd(`CTM_ADDR_CH0_SEL, 0, 32'h0);
		wr(`CTM_ADDR_AVAIL, 32'h0);
		rd(`CTM_ADDR_AVAIL, 0, `CTM_MODES_AVAILABLE);
		rd(16'h0000, 0, 32'h0);
		chk({31'h0, err[1]}, 32'h0);
		wr(`CTM_ADDR_CH1_SEL, 32'h00000002);
		rd(`CTM_ADDR_CH1_SEL, 0, 32'h00000002);
		chk({31'h0, err[1]}, 32'h1);
		rd(`CTM_ADDR_CH1_SEL, 1, 32'h0);
		rd(`CTM_ADDR_STATUS, 1, 32'h1);
		wr(`CTM_ADDR_STATUS, 32'h1);
		chk({31'h0, err[1]}, 32'h0);
		$display("register test done");
		wr(`CTM_ADDR_OR_MASK, 32'h1);
		wr(`CTM_ADDR_CH1_SEL, 32'h0);
		wr(`CTM_ADDR_CH0_LVL0, 32'h8);
		wr(`CTM_ADDR_CH0_LVL1, 32'hFFFFFFF8);
		rd(`CTM_ADDR_CH0_LVL1, 0, 32'hFFFFFFF8);
		foreach (rows[i])
		begin
			wr(`CTM_ADDR_CH0_SEL, rows[i].mode);
			smp(rows[i].prev, Z);
			smp(rows[i].cur, Z);
			o3 = {trig[0], hit[0]};
			chk(32'(o3), 32'({rows[i].hit, 1'b0, rows[i].hit}));
		end
		$display("mode table done");
		wr(`CTM_ADDR_CH0_SEL, 32'h00000008);
		wr(`CTM_ADDR_CH1_SEL, 32'h00000008);
		wr(`CTM_ADDR_CH1_LVL0, 32'h8);
		cmb(2'h0, 2'h0, HI, HI, 3'h3);
		cmb(2'h1, 2'h0, HI, Z, 3'h5);
		cmb(2'h2, 2'h0, HI, Z, 3'h1);
		cmb(2'h0, 2'h3, HI, Z, 3'h1);
		cmb(2'h0, 2'h3, HI, HI, 3'h7);
		cmb(2'h3, 2'h0, HI, HI, 3'h7);
		@(posedge i_clk_sys);
		#1;
		chk({31'h0, trig[0]}, 32'h0);
		$display("combination test done");
		rst(2);
		rd(`CTM_ADDR_OR_MASK, 0, 32'h0);
		$display("second reset test done");
		end_of_test;
	end
endmodule
